// ---- rtl/amc_mode_controller.sv ----
// Top of the amplifier mode controller: pin sync, control registers,
// mode state machine, block gating and soft mute / ramp attenuation.
// Assumes all pins are asynchronous to clk; the host drives the bus.
`timescale 1ns/1ns
`default_nettype none
module amc_mode_controller
  import amc_pkg::*;
#(
  parameter int FAULT_RELEASE_CYC = FAULT_REL_CYC,
  parameter int ADDR_LATCH_CYC = ADS_LATCH_CYC,
  parameter int SAMPLE_TICK_CYC = SAMPLE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_r,
  output logic sda_oe_r,
  input wire logic addr_select_low_pin,
  input wire logic addr_select_high_pin,
  input wire logic bck_in,
  input wire logic lrck_in,
  input wire logic overcurrent_flag,
  input wire logic overvoltage_flag,
  input wire logic undervoltage_flag,
  input wire logic overtemperature_flag,
  output amc_mode_t mode_r,
  output logic pll_en_r,
  output logic audio_if_en_r,
  output logic amp_en_r,
  output logic boost_en_r,
  output logic pwm_float_r,
  output logic [7:0] atten_r,
  output logic [2:0] volume_ramp_select_r
);

  localparam int NSYNC = 10;

  // ==========================================================
  // Pin synchronisers
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] pins;

  assign pins = {scl_in, sda_in, bck_in, lrck_in, addr_select_low_pin,
                 addr_select_high_pin, overcurrent_flag, overvoltage_flag,
                 undervoltage_flag, overtemperature_flag};

  // Two stages; only the second stage is read anywhere
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 10'h300;
      sync2_r <= 10'h300;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  logic scl_s;
  logic sda_s;
  logic bck_s;
  logic lrck_s;
  logic ads_lo_s;
  logic ads_hi_s;
  amc_prot_t prot_s;

  assign scl_s = sync2_r[9];
  assign sda_s = sync2_r[8];
  assign bck_s = sync2_r[7];
  assign lrck_s = sync2_r[6];
  assign ads_lo_s = sync2_r[5];
  assign ads_hi_s = sync2_r[4];
  assign prot_s = sync2_r[3:0];

  // ==========================================================
  // Address pins: low pin is live, high pin is caught once
  localparam int LW = $clog2(ADDR_LATCH_CYC + 1);
  logic [LW-1:0] latch_cnt_r;
  logic ads_hi_r;
  logic [6:0] dev_addr;

  // Caught well after reset so the strap level has settled
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_cnt_r <= '0;
      ads_hi_r <= 1'b0;
    end else if (latch_cnt_r != LW'(ADDR_LATCH_CYC)) begin
      latch_cnt_r <= latch_cnt_r + LW'(1);
      ads_hi_r <= ads_hi_s;
    end
  end

  assign dev_addr = {DEV_ADDR_FIXED, ads_hi_r, ads_lo_s};

  // ==========================================================
  // Serial control slave and clock monitor
  logic wr_stb;
  amc_wr_t wr;
  logic clk_valid;

  amc_i2c_wr u_i2c (
    .clk(clk),
    .rst(rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .dev_addr(dev_addr),
    .sda_oe_r(sda_oe_r),
    .wr_stb_r(wr_stb),
    .wr_r(wr)
  );

  amc_clk_mon u_mon (
    .clk(clk),
    .rst(rst),
    .bck_s(bck_s),
    .lrck_s(lrck_s),
    .valid_r(clk_valid)
  );

  // The bus only pulls low, so the data level is a constant zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  logic [7:0] ctrl_r;

  // Reset leaves power-down requested and the amp disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      volume_ramp_select_r <= VOL_RST[2:0];
    end else if (wr_stb) begin
      if (wr.addr == CTRL_OFS) begin
        ctrl_r <= wr.data;
      end
      if (wr.addr == VOL_OFS) begin
        volume_ramp_select_r <= wr.data[2:0];
      end
    end
  end

  logic power_down_request;
  logic amp_enable_bit;
  logic prot;
  logic run_ok;

  assign power_down_request = ctrl_r[CTRL_POWER_DOWN_REQUEST_BIT];
  assign amp_enable_bit = ctrl_r[CTRL_AMP_ENABLE_BIT_BIT];
  assign prot = |prot_s;
  assign run_ok = clk_valid && !power_down_request && amp_enable_bit;

  // ==========================================================
  // Fault release timer
  localparam int FW = $clog2(FAULT_RELEASE_CYC + 1);
  logic [FW-1:0] rel_cnt_r;
  logic rel_done;

  assign rel_done = (rel_cnt_r == FW'(FAULT_RELEASE_CYC));

  // Any new event restarts the full checking cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rel_cnt_r <= '0;
    end else if (mode_r != MODE_FAULT || prot) begin
      rel_cnt_r <= '0;
    end else if (!rel_done) begin
      rel_cnt_r <= rel_cnt_r + FW'(1);
    end
  end

  // ==========================================================
  // Mode state machine
  amc_mode_t mode_nxt;
  logic mute_done;

  assign mute_done = (atten_r == ATTEN_MAX);

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_POWER_DOWN_REQUEST: begin
        if (!power_down_request) begin
          if (prot) begin
            mode_nxt = MODE_FAULT;
          end else if (run_ok) begin
            mode_nxt = MODE_OP;
          end else begin
            mode_nxt = MODE_SUSPEND_STATE;
          end
        end
      end
      MODE_FAULT: begin
        if (power_down_request) begin
          mode_nxt = MODE_POWER_DOWN_REQUEST;
        end else if (rel_done) begin
          mode_nxt = run_ok ? MODE_OP : MODE_SUSPEND_STATE;
        end
      end
      MODE_SUSPEND_STATE: begin
        if (power_down_request) begin
          mode_nxt = MODE_POWER_DOWN_REQUEST;
        end else if (prot) begin
          mode_nxt = MODE_FAULT;
        end else if (run_ok) begin
          mode_nxt = MODE_OP;
        end
      end
      MODE_OP: begin
        if (power_down_request) begin
          mode_nxt = MODE_POWER_DOWN_REQUEST;
        end else if (prot) begin
          mode_nxt = MODE_FAULT;
        end else if (!run_ok && mute_done) begin
          mode_nxt = MODE_SUSPEND_STATE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= MODE_POWER_DOWN_REQUEST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // Block gating, registered from the next mode
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_en_r <= 1'b0;
      audio_if_en_r <= 1'b0;
      amp_en_r <= 1'b0;
      boost_en_r <= 1'b0;
      pwm_float_r <= 1'b1;
    end else begin
      pll_en_r <= (mode_nxt != MODE_POWER_DOWN_REQUEST);
      audio_if_en_r <= (mode_nxt == MODE_OP) || (mode_nxt == MODE_FAULT);
      amp_en_r <= (mode_nxt == MODE_OP);
      boost_en_r <= (mode_nxt == MODE_OP) || (mode_nxt == MODE_SUSPEND_STATE);
      pwm_float_r <= (mode_nxt != MODE_OP);
    end
  end

  // ==========================================================
  // Sample pacing for the ramp; free-running so a lost
  // audio clock cannot stall the soft mute
  localparam int SW = $clog2(SAMPLE_TICK_CYC + 1);
  logic [SW-1:0] samp_cnt_r;
  logic samp_tick;
  logic [5:0] step_cnt_r;
  logic step_now;
  logic [5:0] step_len;

  assign samp_tick = (samp_cnt_r == SW'(SAMPLE_TICK_CYC - 1));

  // Samples per 0.5 dB step: 1, 2, 4 ... 64
  assign step_len = 6'((7'h01 << (volume_ramp_select_r - 3'h1)) - 7'h01);
  assign step_now = samp_tick && (step_cnt_r >= step_len);

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_r <= '0;
      step_cnt_r <= '0;
    end else begin
      samp_cnt_r <= samp_tick ? '0 : samp_cnt_r + SW'(1);
      if (step_now) begin
        step_cnt_r <= '0;
      end else if (samp_tick) begin
        step_cnt_r <= step_cnt_r + 6'h01;
      end
    end
  end

  // ==========================================================
  // Attenuation: full outside operating, ramps inside it
  always_ff @(posedge clk) begin
    if (rst) begin
      atten_r <= ATTEN_MAX;
    end else if (mode_r != MODE_OP) begin
      atten_r <= ATTEN_MAX;
    end else if (!run_ok) begin
      // Soft mute before the amp is switched off
      if (volume_ramp_select_r == 3'h0) begin
        atten_r <= ATTEN_MAX;
      end else if (step_now && !mute_done) begin
        atten_r <= atten_r + 8'h01;
      end
    end else begin
      if (volume_ramp_select_r == 3'h0) begin
        atten_r <= 8'h00;
      end else if (step_now && atten_r != 8'h00) begin
        atten_r <= atten_r - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/amc_pkg.sv ----
// Constants, types and helpers shared by the amplifier mode controller.
// Assumes a 50 MHz system clock and synchronous active-high reset.
//
// Summary of operation
// - Four modes held in one state machine
// - Power-down bit set: power down, float PWM
// - Bad bit clock or rate: suspend, monitor
// - Operate only when clocks valid, enabled, up
// - Protection event: fault, boost and amp off
// - Leave fault after 200 ms released
// - Gate PLL, serial audio, amp per mode
// - Reset starts in power-down mode
// - Early power-up without clock goes to suspend
// - Ramp up on every entry to operating
// - Clock loss: soft mute, then amp off
// - Clock back: operate again with ramp up
// - Ramp code selects samples per 0.5 dB step
// - Acknowledge device address and register address
// - Acknowledge every data byte, auto-increment
// - Address is 01101, high pin, low pin
package amc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h03;
  localparam logic [7:0] VOL_OFS = 8'h28;
  localparam int CTRL_AMP_ENABLE_BIT_BIT = 0;
  localparam int CTRL_POWER_DOWN_REQUEST_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] VOL_RST = 8'h00;
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h0D;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int MON_PERIOD_NS = 1000;
  localparam int MON_CYC = MON_PERIOD_NS * CLK_MHZ / 1000;
  localparam int FAULT_REL_MS = 200;
  localparam int FAULT_REL_CYC = FAULT_REL_MS * CLK_MHZ * 1000;
  localparam int ADS_LATCH_US = 768;
  localparam int ADS_LATCH_CYC = ADS_LATCH_US * CLK_MHZ;
  localparam int BCK_TIMEOUT_US = 2;
  localparam int SR_TIMEOUT_US = 250;
  localparam int SAMPLE_NS = 20833;
  localparam int SAMPLE_CYC = SAMPLE_NS * CLK_MHZ / 1000;
  localparam logic [7:0] ATTEN_MAX = 8'h78;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_POWER_DOWN_REQUEST, MODE_SUSPEND_STATE, MODE_OP, MODE_FAULT} amc_mode_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_REG, PH_DATA} amc_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } amc_wr_t;

  typedef struct packed {
    logic oc;
    logic ov;
    logic uv;
    logic ot;
  } amc_prot_t;

  // Bit clocks per frame that a valid format may use
  function automatic logic amc_ratio_ok(input logic [9:0] n);
    return (n == 10'h020) || (n == 10'h030) || (n == 10'h040) ||
           (n == 10'h080) || (n == 10'h100);
  endfunction

endpackage

// ---- rtl/amc_clk_mon.sv ----
// Bit clock and sample rate checker on a 1 MHz monitor tick.
// Assumes bck and lrck were already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module amc_clk_mon
  import amc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bck_s,
  input wire logic lrck_s,
  output logic valid_r
);

  logic bck_d_r;
  logic lrck_d_r;
  logic [5:0] tick_cnt_r;
  logic tick;
  logic [7:0] bck_age_r;
  logic [8:0] sr_age_r;
  logic [9:0] bck_cnt_r;
  logic sr_ok_r;
  logic bck_rise;
  logic lrck_rise;

  assign bck_rise = bck_s & ~bck_d_r;
  assign lrck_rise = lrck_s & ~lrck_d_r;
  assign tick = (tick_cnt_r == 6'(MON_CYC - 1));

  // ==========================================================
  // Edge history and 1 MHz monitor tick
  always_ff @(posedge clk) begin
    if (rst) begin
      bck_d_r <= 1'b0;
      lrck_d_r <= 1'b0;
      tick_cnt_r <= '0;
    end else begin
      bck_d_r <= bck_s;
      lrck_d_r <= lrck_s;
      tick_cnt_r <= tick ? 6'h00 : tick_cnt_r + 6'h01;
    end
  end

  // Ages in monitor ticks since the last edges
  always_ff @(posedge clk) begin
    if (rst) begin
      bck_age_r <= 8'hFF;
      sr_age_r <= 9'h1FF;
    end else begin
      if (bck_rise) begin
        bck_age_r <= '0;
      end else if (tick && bck_age_r != 8'hFF) begin
        bck_age_r <= bck_age_r + 8'h01;
      end
      if (lrck_rise) begin
        sr_age_r <= '0;
      end else if (tick && sr_age_r != 9'h1FF) begin
        sr_age_r <= sr_age_r + 9'h001;
      end
    end
  end

  // Bit clocks per frame decide the rate check
  always_ff @(posedge clk) begin
    if (rst) begin
      bck_cnt_r <= '0;
      sr_ok_r <= 1'b0;
    end else begin
      if (lrck_rise) begin
        bck_cnt_r <= 10'(bck_rise);
        sr_ok_r <= amc_ratio_ok(bck_cnt_r);
      end else begin
        if (bck_rise && bck_cnt_r != 10'h3FF) begin
          bck_cnt_r <= bck_cnt_r + 10'h001;
        end
        if (sr_age_r >= 9'(SR_TIMEOUT_US)) begin
          sr_ok_r <= 1'b0;
        end
      end
    end
  end

  // Both checks must pass to call the audio clock valid
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= sr_ok_r && (bck_age_r < 8'(BCK_TIMEOUT_US));
    end
  end

endmodule
`default_nettype wire

// ---- rtl/amc_i2c_wr.sv ----
// Two-wire serial write slave: start/stop, address match, ack, writes.
// Assumes scl and sda were already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module amc_i2c_wr
  import amc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [6:0] dev_addr,
  output logic sda_oe_r,
  output logic wr_stb_r,
  output amc_wr_t wr_r
);

  logic scl_d_r;
  logic sda_d_r;
  logic [7:0] sh_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] reg_addr_r;
  amc_phase_t ph_r;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;

  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // ==========================================================
  // Byte framing; reads are not acknowledged
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_r <= PH_IDLE;
      bit_cnt_r <= '0;
      sh_r <= '0;
      reg_addr_r <= '0;
      sda_oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_r <= '0;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_c) begin
        ph_r <= PH_ADDR;
        bit_cnt_r <= '0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        ph_r <= PH_IDLE;
        sda_oe_r <= 1'b0;
      end else if (ph_r != PH_IDLE) begin
        if (scl_rise && bit_cnt_r < 4'h8) begin
          sh_r <= {sh_r[6:0], sda_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (scl_fall && bit_cnt_r == 4'h8) begin
          bit_cnt_r <= 4'h9;
          unique case (ph_r)
            PH_ADDR: begin
              if (sh_r[7:1] == dev_addr && !sh_r[0]) begin
                sda_oe_r <= 1'b1;
                ph_r <= PH_REG;
              end else begin
                ph_r <= PH_IDLE;
              end
            end
            PH_REG: begin
              reg_addr_r <= sh_r;
              sda_oe_r <= 1'b1;
              ph_r <= PH_DATA;
            end
            PH_DATA: begin
              wr_r <= '{addr: reg_addr_r, data: sh_r};
              wr_stb_r <= 1'b1;
              reg_addr_r <= reg_addr_r + 8'h01;
              sda_oe_r <= 1'b1;
            end
            PH_IDLE: begin
              sda_oe_r <= 1'b0;
            end
          endcase
        end else if (scl_fall && bit_cnt_r == 4'h9) begin
          // Release after the ack clock so the host owns data again
          sda_oe_r <= 1'b0;
          bit_cnt_r <= '0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/amc_mode_controller_chk.sv ----
// Concurrent checks on the mode controller's ports: gating, faults, mute, ack.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module amc_mode_controller_chk
  import amc_pkg::*;
#(
  parameter int FAULT_RELEASE_CYC = 200
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_oe_r,
  input wire logic overcurrent_flag,
  input wire logic overvoltage_flag,
  input wire logic undervoltage_flag,
  input wire logic overtemperature_flag,
  input wire amc_mode_t mode_r,
  input wire logic pll_en_r,
  input wire logic audio_if_en_r,
  input wire logic amp_en_r,
  input wire logic boost_en_r,
  input wire logic pwm_float_r,
  input wire logic [7:0] atten_r,
  input wire logic [2:0] volume_ramp_select_r
);
  // ==========================================================
  // Helper logic
  logic flag_any;
  int quiet_cnt;
  assign flag_any = overcurrent_flag | overvoltage_flag | undervoltage_flag | overtemperature_flag;

  // Quiet time on raw pins; saturates so it never wraps in long runs
  always_ff @(posedge clk) begin
    if (rst || flag_any) begin
      quiet_cnt <= 0;
    end else if (quiet_cnt < FAULT_RELEASE_CYC) begin
      quiet_cnt <= quiet_cnt + 1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_amp_gate:
    assert property (amp_en_r == (mode_r == MODE_OP))
    else $error("amplifier enable disagrees with mode");
  chk_pll_gate:
    assert property (pll_en_r == (mode_r != MODE_POWER_DOWN_REQUEST))
    else $error("pll enable disagrees with mode");
  chk_audio_gate:
    assert property (audio_if_en_r == (mode_r inside {MODE_OP, MODE_FAULT}))
    else $error("audio interface enable disagrees with mode");
  chk_pwm_float:
    assert property (pwm_float_r == (mode_r != MODE_OP))
    else $error("pwm float disagrees with mode");
  chk_fault_off:
    assert property (mode_r == MODE_FAULT |-> !boost_en_r && !amp_en_r)
    else $error("boost or amplifier on in fault mode");
  chk_fault_entry:
    assert property (flag_any [*6] |-> mode_r inside {MODE_FAULT, MODE_POWER_DOWN_REQUEST})
    else $error("protection flag held without fault mode");
  chk_fault_hold:
    assert property ($past(mode_r) == MODE_FAULT && mode_r inside {MODE_OP, MODE_SUSPEND_STATE}
      |-> quiet_cnt >= FAULT_RELEASE_CYC)
    else $error("fault mode left before release time");
  chk_mute_first:
    assert property ($past(mode_r) == MODE_OP && mode_r == MODE_SUSPEND_STATE |-> atten_r == ATTEN_MAX)
    else $error("suspend entered before soft mute finished");
  chk_ramp_entry:
    assert property (mode_r == MODE_OP && $past(mode_r) inside {MODE_POWER_DOWN_REQUEST, MODE_SUSPEND_STATE}
      && volume_ramp_select_r != 3'h0 |-> atten_r != 8'h00)
    else $error("operating mode entered without ramp");
  chk_ack_hold:
    assert property ($rose(sda_oe_r) |-> !scl_in ##1 sda_oe_r [*8])
    else $error("acknowledge not held through its bit");

  // Main scenarios reached
  cov_fault: cover property (mode_r == MODE_FAULT);
  cov_mute: cover property ($past(mode_r) == MODE_OP && mode_r == MODE_SUSPEND_STATE);
  cov_ack: cover property ($rose(sda_oe_r));
  cov_ramp_done: cover property (mode_r == MODE_OP && atten_r == 8'h00);
endmodule

bind amc_mode_controller amc_mode_controller_chk #(.FAULT_RELEASE_CYC(FAULT_RELEASE_CYC)) u_chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_oe_r(sda_oe_r),
  .overcurrent_flag(overcurrent_flag), .overvoltage_flag(overvoltage_flag),
  .undervoltage_flag(undervoltage_flag), .overtemperature_flag(overtemperature_flag),
  .mode_r(mode_r), .pll_en_r(pll_en_r), .audio_if_en_r(audio_if_en_r), .amp_en_r(amp_en_r),
  .boost_en_r(boost_en_r), .pwm_float_r(pwm_float_r), .atten_r(atten_r),
  .volume_ramp_select_r(volume_ramp_select_r));
`default_nettype wire

// ---- verif/amc_host_model.sv ----
// Host on the two-wire control bus: write transactions only.
// Assumes a pull-up on the data line; 24 clocks per bus bit.
`timescale 1ns/1ns
`default_nettype none
module amc_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_r,
  output logic sda_low_r
);
  // ==========================================================
  // Bus timing: quarter bit, keeps both clock phases far above minimum
  localparam int Q = 6;

  // Bus idles with both lines released
  initial begin
    scl_r = 1'b1;
    sda_low_r = 1'b0;
  end

  // One bit: data set while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic seen);
    sda_low_r <= !b;
    repeat (Q) @(posedge clk);
    scl_r <= 1'b1;
    repeat (Q) @(posedge clk);
    seen = sda_line;
    repeat (Q) @(posedge clk);
    scl_r <= 1'b0;
    repeat (Q) @(posedge clk);
  endtask

  // Eight bits MSB first, then the acknowledge bit with data released
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // ==========================================================
  // Write: start, address with write bit, register, data, stop
  task automatic write(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d[$],
                       output logic ack);
    logic a;
    sda_low_r <= 1'b1;
    repeat (2 * Q) @(posedge clk);
    scl_r <= 1'b0;
    repeat (Q) @(posedge clk);
    put_byte({dev, 1'b0}, ack);
    put_byte(ra, a);
    ack &= a;
    foreach (d[i]) begin
      put_byte(d[i], a);
      ack &= a;
    end
    sda_low_r <= 1'b1;
    repeat (Q) @(posedge clk);
    scl_r <= 1'b1;
    repeat (2 * Q) @(posedge clk);
    sda_low_r <= 1'b0;
    repeat (4 * Q) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verif/amp_mode_controller_test.sv ----
// Self-checking bench for the amplifier mode controller.
// Assumes the host model drives the bus; audio clocks and flags come from here.
`timescale 1ns/1ns
`default_nettype none
module amp_mode_controller_test;
  import amc_pkg::*;
  localparam int REL = 200;
  logic clk, rst, bck, lrck, lo_pin, hi_pin, clk_on;
  logic [3:0] prot;
  logic sda_out, sda_oe, pll, aud, amp, bst, flt;
  logic [7:0] atten;
  logic [2:0] rsel;
  amc_mode_t mode;
  wire logic scl, host_low, sda_line;
  int errors, cmp_count, bcnt, n;

  // ==========================================================
  // Wiring: open-drain data line with pull-up
  assign sda_line = !(host_low || (sda_oe && !sda_out));

  amc_host_model host (.clk(clk), .sda_line(sda_line), .scl_r(scl), .sda_low_r(host_low));

  amc_mode_controller #(.FAULT_RELEASE_CYC(REL), .ADDR_LATCH_CYC(8), .SAMPLE_TICK_CYC(8)) uut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out_r(sda_out),
    .sda_oe_r(sda_oe), .addr_select_low_pin(lo_pin), .addr_select_high_pin(hi_pin),
    .bck_in(bck), .lrck_in(lrck), .overcurrent_flag(prot[0]), .overvoltage_flag(prot[1]),
    .undervoltage_flag(prot[2]), .overtemperature_flag(prot[3]), .mode_r(mode),
    .pll_en_r(pll), .audio_if_en_r(aud), .amp_en_r(amp), .boost_en_r(bst),
    .pwm_float_r(flt), .atten_r(atten), .volume_ramp_select_r(rsel));

  // ==========================================================
  // Clocks: 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Audio clocks: 160 ns bit clock, 32 per frame; frozen when switched off
  always @(posedge clk) begin
    if (rst) begin
      bcnt <= 0;
      bck <= 1'b0;
      lrck <= 1'b0;
    end else if (clk_on) begin
      bcnt <= bcnt + 1;
      if (bcnt % 4 == 3) bck <= !bck;
      if (bcnt % 128 == 127) lrck <= !lrck;
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for a mode, then compare
  task automatic wait_mode(input amc_mode_t m, input int lim);
    int k;
    k = 0;
    while (mode !== m && k < lim) begin
      @(posedge clk);
      k++;
    end
    check("mode", mode, m);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d[$],
                    input logic exp_ack);
    logic ack;
    host.write(dev, ra, d, ack);
    check("ack", ack, exp_ack);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    clk_on = 1'b0;
    lo_pin = 1'b0;
    hi_pin = 1'b0;
    prot = 4'h0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    check("mode", mode, MODE_POWER_DOWN_REQUEST);
    check("gates", {flt, pll, aud, amp, bst}, 8'h10);
    check("atten", atten, ATTEN_MAX);
    check("ramp sel", rsel, 3'h0);
    check("sda drive", sda_out, 8'h00);
    $display("test reset done");
    // High select pin is latched already; low select pin stays live
    hi_pin <= 1'b1;
    lo_pin <= 1'b1;
    wr(7'h36, 8'h03, '{8'h01}, 1'b0);
    wr(7'h34, 8'h03, '{8'h01}, 1'b0);
    check("mode", mode, MODE_POWER_DOWN_REQUEST);
    wr(7'h35, 8'h27, '{8'h00, 8'h01, 8'h00}, 1'b1);
    check("ramp sel", rsel, 3'h1);
    $display("test address done");
    wr(7'h35, 8'h03, '{8'h01}, 1'b1);
    wait_mode(MODE_SUSPEND_STATE, 50);
    check("gates", {flt, pll, aud, amp, bst}, 8'h19);
    clk_on <= 1'b1;
    wait_mode(MODE_OP, 20000);
    check("gates", {flt, pll, aud, amp, bst}, 8'h0F);
    check("ramp start", atten != 8'h00, 1'b1);
    n = 0;
    while (atten !== 8'h00 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("ramp time", n >= 119 * 8 && n <= 121 * 8, 1'b1);
    $display("test operate done");
    clk_on <= 1'b0;
    wait_mode(MODE_SUSPEND_STATE, 3000);
    check("muted", atten, ATTEN_MAX);
    clk_on <= 1'b1;
    wait_mode(MODE_OP, 20000);
    check("ramp start", atten != 8'h00, 1'b1);
    $display("test clock loss done");
    // Each protection flag alone; release must wait the full count
    for (int i = 0; i < 4; i++) begin
      prot <= 4'h1 << i;
      wait_mode(MODE_FAULT, 20);
      check("gates", {flt, pll, aud, amp, bst}, 8'h1C);
      prot <= 4'h0;
      n = 0;
      while (mode === MODE_FAULT && n < 1000) begin
        @(posedge clk);
        n++;
      end
      check("release wait", n >= REL, 1'b1);
      wait_mode(MODE_OP, 300);
    end
    $display("test fault done");
    prot <= 4'h8;
    wait_mode(MODE_FAULT, 20);
    wr(7'h35, 8'h03, '{8'h03}, 1'b1);
    wait_mode(MODE_POWER_DOWN_REQUEST, 30);
    check("gates", {flt, pll, aud, amp, bst}, 8'h10);
    prot <= 4'h0;
    // Ramp code zero: full level from the second operating cycle
    wr(7'h35, 8'h28, '{8'h00}, 1'b1);
    wr(7'h35, 8'h03, '{8'h01}, 1'b1);
    wait_mode(MODE_OP, 20000);
    repeat (2) @(posedge clk);
    check("no ramp", atten, 8'h00);
    $display("test priority done");
    print_verdict();
  end

  // Watchdog: all tests take about a third of this span
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("[FAIL] watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
